// *** design/bbc_pkg.sv ***
// constants shared by the bit and block error checker files
// assumes a 20 MHz system clock and 32-bit classic wishbone registers
package bbc_pkg;
  // wishbone word index, byte address is four times this
  localparam logic [3:0]  A_CTRL    = 4'h0; // control, read/write
  localparam logic [3:0]  A_CMD     = 4'h1; // single-shot triggers, write only
  localparam logic [3:0]  A_STAT    = 4'h2; // status flags and end causes
  localparam logic [3:0]  A_MAXB    = 4'h3; // bit count limit
  localparam logic [3:0]  A_MAXE    = 4'h4; // bit error limit
  localparam logic [3:0]  A_BITS    = 4'h5; // checked bits
  localparam logic [3:0]  A_ERRS    = 4'h6; // errored bits
  localparam logic [3:0]  A_MAXK    = 4'h7; // block count limit
  localparam logic [3:0]  A_MAXKE   = 4'h8; // block error limit
  localparam logic [3:0]  A_BLKS    = 4'h9; // checked blocks
  localparam logic [3:0]  A_BERRS   = 4'ha; // errored blocks
  // control field positions
  localparam int          C_ON      = 0;    // bit measurement enable
  localparam int          C_AUTO    = 1;    // continuous bit measurement
  localparam int          C_RST     = 2;    // outside restart enable
  localparam int          C_QM      = 3;    // qualifier mode, two bits
  localparam int          C_IM      = 5;    // run exclusion mode, two bits
  localparam int          C_NEG     = 7;    // falling bit clock edge active
  localparam int          C_INV     = 8;    // inverted data polarity
  localparam int          C_BON     = 9;    // block measurement enable
  localparam int          C_BAUTO   = 10;   // continuous block measurement
  // command field positions
  localparam int          K_GO      = 0;    // single bit measurement trigger
  localparam int          K_BGO     = 1;    // single block measurement trigger
  // reset values
  localparam logic [10:0] RST_CTRL  = 11'h000;
  localparam logic [31:0] RST_MAXB  = 32'h00100000;
  localparam logic [31:0] RST_MAXE  = 32'h00001000;
  localparam logic [31:0] RST_MAXK  = 32'h00000400;
  localparam logic [31:0] RST_MAXKE = 32'h00000064;
  // qualifier modes
  localparam logic [1:0]  Q_OFF     = 2'h0;
  localparam logic [1:0]  Q_HIGH    = 2'h1;
  localparam logic [1:0]  Q_LOW     = 2'h2;
  // run exclusion modes
  localparam logic [1:0]  I_OFF     = 2'h0;
  localparam logic [1:0]  I_ONES    = 2'h1;
  localparam logic [1:0]  I_ZEROS   = 2'h2;
  // end causes
  localparam logic [1:0]  E_NONE    = 2'h0;
  localparam logic [1:0]  E_USER    = 2'h1;
  localparam logic [1:0]  E_COUNT   = 2'h2;
  localparam logic [1:0]  E_ERRS    = 2'h3;
  // run length and reference register length
  localparam logic [5:0]  RUN_LEN   = 6'h20;
  localparam logic [3:0]  PRBS_LEN  = 4'h9;
  // activity detection window
  localparam int          CLK_MHZ   = 20;
  localparam int          DET_US    = 100;
  localparam logic [11:0] DET_CYC   = 12'(DET_US * CLK_MHZ);
  // measurement states, gray along idle-sync-run-done
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SYNC = 3'b001,
    S_RUN  = 3'b011,
    S_DONE = 3'b010,
    S_HALT = 3'b111
  } bbc_state_t;
endpackage

// *** design/bbc_in_sync.sv ***
// two-stage synchroniser for the four tester pins plus one history stage
// assumes pins are asynchronous to clk; only stage two feeds stage three
`timescale 1ns/1ns
module bbc_in_sync (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [3:0] pin,
  output logic      [3:0] now,
  output logic      [3:0] prev
);
  // all state of the synchroniser
  typedef struct packed {
    logic [3:0] s1; // metastable stage, read by s2 only
    logic [3:0] s2; // settled level
    logic [3:0] s3; // one cycle older, for edges
  } bbc_sync_t;

  bbc_sync_t r;
  bbc_sync_t n;

  // shift the pins through the stages
  always_comb begin
    n    = r;
    n.s1 = pin;
    n.s2 = r.s1;
    n.s3 = r.s2;
  end

  // register the copy
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign now  = r.s2;
  assign prev = r.s3;
endmodule

// *** design/bbc_ref_gen.sv ***
// reference sequence register, x^9 + x^5 + 1, self-loading from data
// assumes adv is a one-cycle step and rx is the bit under test
`timescale 1ns/1ns
module bbc_ref_gen (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic adv,
  input  wire logic load,
  input  wire logic rx,
  output logic      ref_bit
);
  // all state of the generator
  typedef struct packed {
    logic [8:0] sr; // reference shift register
  } bbc_ref_t;

  bbc_ref_t r;
  bbc_ref_t n;

  // next predicted bit from the feedback taps
  assign ref_bit = r.sr[8] ^ r.sr[4];

  // load takes the received bit, otherwise run on the prediction
  always_comb begin
    n = r;
    if (adv) begin
      n.sr = {r.sr[7:0], load ? rx : ref_bit};
    end
  end

  // register the copy; all ones avoids the stuck zero state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= '1;
    end else begin
      r <= n;
    end
  end
endmodule

// *** design/bbc_checker.sv ***
// bit and block error checker: wishbone registers, pin conditioning,
// run exclusion, reference compare, bit and block counters
// assumes a classic wishbone master on clk and asynchronous tester pins
//
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
module bbc_checker (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [5:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic      [31:0] wb_dat_r,
  output logic             wb_ack,
  input  wire logic        tst_clk,
  input  wire logic        tst_data,
  input  wire logic        tst_qual,
  input  wire logic        tst_restart
);
  // all state of the checker
  typedef struct packed {
    logic                ack;   // bus answer
    logic [31:0]         rdat;  // read data
    logic [10:0]         ctrl;  // control fields
    logic [31:0]         maxb;  // bit limit
    logic [31:0]         maxe;  // bit error limit
    logic [31:0]         maxk;  // block limit
    logic [31:0]         maxke; // block error limit
    bbc_pkg::bbc_state_t st;    // bit measurement state
    logic [31:0]         bits;  // checked bits
    logic [31:0]         errs;  // errored bits
    logic [1:0]          cause; // bit end cause
    logic                bact;  // block measurement running
    logic [31:0]         blks;  // checked blocks
    logic [31:0]         berrs; // errored blocks
    logic [1:0]          bcause; // block end cause
    logic                inblk; // a block is open
    logic                bbad;  // open block saw an error
    logic [11:0]         ccnt;  // cycles since last clock edge
    logic [11:0]         dcnt;  // cycles since last data change
    logic                clk_ok; // clock present
    logic                data_ok; // data present
    logic                sync;  // synchronised flag
    logic                last;  // previous sampled data
    logic                rsp;   // previous sampled restart
    logic [31:0]         dly;   // run detector delay line
    logic [31:0]         ign;   // exclusion mark per held bit
    logic [5:0]          fill;  // held bits in delay line
    logic [5:0]          run;   // current run length
    logic [3:0]          lcnt;  // reference bits loaded
  } bbc_regs_t;

  bbc_regs_t   r;
  bbc_regs_t   n;
  logic [3:0]  now;      // synchronised pins
  logic [3:0]  prev;     // pins one cycle older
  logic        bit_stb;  // active bit clock edge seen
  logic [1:0]  qm;       // qualifier mode
  logic [1:0]  im;       // exclusion mode
  logic        q;        // current bit qualified
  logic        d;        // current bit after polarity
  logic        ign_on;   // exclusion selected
  logic        o;        // bit leaving the detector
  logic        o_ok;     // that bit is real
  logic        o_ex;     // that bit is excluded
  logic        ref_bit;  // predicted bit
  logic        mism;     // compare error
  logic        rs_rise;  // restart rising at bit edge
  logic        rs_fall;  // restart falling at bit edge
  logic        active;   // synchronising or running
  logic        wr;       // write taking effect now
  logic        adv;      // step the reference
  logic        load;     // load reference from data
  logic        close;    // block closes this cycle
  logic [5:0]  run_n;    // run length after this bit
  logic [31:0] wctrl;    // merged control write
  logic [31:0] bits_n;   // bits plus one
  logic [31:0] errs_n;   // errors plus this one
  logic [31:0] blks_n;   // blocks plus one
  logic [31:0] berrs_n;  // block errors plus this one

  // byte-lane merge for wishbone writes
  function automatic logic [31:0] bbc_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[8*i+:8] = nw[8*i+:8];
      end
    end
    return m;
  endfunction

  // pins: clock, data, qualifier, restart
  bbc_in_sync u_sync (
    .clk   (clk),
    .reset (reset),
    .pin   ({tst_restart, tst_qual, tst_data, tst_clk}),
    .now   (now),
    .prev  (prev)
  );

  // reference sequence, stepped on every qualified bit leaving the detector, excluded ones too
  bbc_ref_gen u_ref (
    .clk     (clk),
    .reset   (reset),
    .adv     (adv),
    .load    (load),
    .rx      (o),
    .ref_bit (ref_bit)
  );

  // edge select on the settled clock level
  assign bit_stb = r.ctrl[bbc_pkg::C_NEG] ? (prev[0] & ~now[0]) : (~prev[0] & now[0]);
  assign d       = now[1] ^ r.ctrl[bbc_pkg::C_INV];
  assign qm      = r.ctrl[bbc_pkg::C_QM+:2];
  assign im      = r.ctrl[bbc_pkg::C_IM+:2];
  // qualifier sampled in the same stage as data, so pins must be stable at the edge
  assign q       = (qm == bbc_pkg::Q_HIGH) ? now[2] :
                   (qm == bbc_pkg::Q_LOW)  ? ~now[2] :
                   (qm == bbc_pkg::Q_OFF);
  assign ign_on  = (im == bbc_pkg::I_ONES) | (im == bbc_pkg::I_ZEROS);
  // with exclusion the compare sees bits 32 strobes late
  assign o       = ign_on ? r.dly[31] : d;
  assign o_ok    = ign_on ? (r.fill == bbc_pkg::RUN_LEN) : 1'b1;
  assign o_ex    = ign_on & r.ign[31];
  assign mism    = o ^ ref_bit;
  // restart pin only matters when enabled
  assign rs_rise = bit_stb & r.ctrl[bbc_pkg::C_RST] & now[3] & ~r.rsp;
  assign rs_fall = bit_stb & r.ctrl[bbc_pkg::C_RST] & ~now[3] & r.rsp;
  assign active  = (r.st == bbc_pkg::S_SYNC) | (r.st == bbc_pkg::S_RUN);
  // writes land at the edge where the master sees ack
  assign wr      = wb_cyc & wb_stb & wb_we & r.ack;
  assign close   = r.inblk & ((bit_stb & ~q) | rs_rise);
  assign run_n   = (d != (im == bbc_pkg::I_ONES)) ? 6'h00 :
                   (r.run == bbc_pkg::RUN_LEN) ? r.run : r.run + 6'h01;
  assign bits_n  = r.bits + 32'h1;
  assign errs_n  = r.errs + {31'h0, mism};
  assign blks_n  = r.blks + 32'h1;
  assign berrs_n = r.berrs + {31'h0, r.bbad};

  // next state of the whole checker
  always_comb begin
    n     = r;
    wctrl = bbc_merge({21'h0, r.ctrl}, wb_dat_w, wb_sel);
    adv   = 1'b0;
    load  = 1'b0;
    n.ack = wb_cyc & wb_stb & ~r.ack;
    // clock activity: any active edge within the window
    if (bit_stb) begin
      n.ccnt = 12'h000;
      n.rsp  = now[3];
      n.last = now[1];
    end else if (r.ccnt != bbc_pkg::DET_CYC) begin
      n.ccnt = r.ccnt + 12'h001;
    end
    // data activity: only clocked-in changes count
    if (bit_stb && (now[1] != r.last)) begin
      n.dcnt = 12'h000;
    end else if (r.dcnt != bbc_pkg::DET_CYC) begin
      n.dcnt = r.dcnt + 12'h001;
    end
    n.clk_ok  = (n.ccnt != bbc_pkg::DET_CYC);
    n.data_ok = (n.dcnt != bbc_pkg::DET_CYC);
    // restart events outrank the bit path
    if (rs_rise && active) begin
      // flush the detector; held bits are never evaluated
      n.st   = bbc_pkg::S_HALT;
      n.fill = 6'h00;
      n.run  = 6'h00;
      n.ign  = 32'h0;
    end else if (r.st == bbc_pkg::S_HALT) begin
      // resume on fall, or at once if restart got disabled
      if (rs_fall || !r.ctrl[bbc_pkg::C_RST]) begin
        n.st   = bbc_pkg::S_SYNC;
        n.lcnt = 4'h0;
      end
    end else if (bit_stb && q && active) begin
      if (ign_on) begin
        // shift the new bit in, mark a long enough run
        n.dly  = {r.dly[30:0], d};
        n.run  = run_n;
        n.ign  = (run_n == bbc_pkg::RUN_LEN) ? 32'hffffffff : {r.ign[30:0], 1'b0};
        n.fill = (r.fill == bbc_pkg::RUN_LEN) ? r.fill : r.fill + 6'h01;
      end
      if (o_ok) begin
        adv = 1'b1;
        if (r.st == bbc_pkg::S_SYNC) begin
          // load the reference from real bits only
          if (!o_ex) begin
            load   = 1'b1;
            n.lcnt = (r.lcnt == bbc_pkg::PRBS_LEN) ? r.lcnt : r.lcnt + 4'h1;
          end
          if (n.lcnt == bbc_pkg::PRBS_LEN && r.clk_ok && r.data_ok) begin
            n.st = bbc_pkg::S_RUN;
          end
        end else if (!o_ex) begin
          // counts carry on across subintervals
          n.bits = bits_n;
          n.errs = errs_n;
          if (r.bact) begin
            n.inblk = 1'b1;
            n.bbad  = r.bbad | mism;
          end
          if (errs_n >= r.maxe || bits_n >= r.maxb) begin
            n.cause = (errs_n >= r.maxe) ? bbc_pkg::E_ERRS : bbc_pkg::E_COUNT;
            if (r.ctrl[bbc_pkg::C_AUTO]) begin
              n.bits = 32'h0;
              n.errs = 32'h0;
            end else begin
              n.st = bbc_pkg::S_DONE;
            end
          end
        end
      end
    end
    // a block ends when qualification drops or restart rises
    if (close) begin
      n.inblk = 1'b0;
      n.bbad  = 1'b0;
      if (r.bact) begin
        n.blks  = blks_n;
        n.berrs = berrs_n;
        if (berrs_n >= r.maxke || blks_n >= r.maxk) begin
          n.bcause = (berrs_n >= r.maxke) ? bbc_pkg::E_ERRS : bbc_pkg::E_COUNT;
          if (r.ctrl[bbc_pkg::C_BAUTO]) begin
            n.blks  = 32'h0;
            n.berrs = 32'h0;
          end else begin
            n.bact = 1'b0;
          end
        end
      end
    end
    // register writes win over everything above
    if (wr) begin
      case (wb_adr[5:2])
        bbc_pkg::A_CTRL: begin
          n.ctrl = wctrl[10:0];
          // start on enable in auto, or on a mode change mid-run
          if ((wctrl[bbc_pkg::C_ON] && !r.ctrl[bbc_pkg::C_ON] && wctrl[bbc_pkg::C_AUTO]) ||
              ((active || r.st == bbc_pkg::S_HALT) && wctrl[6:3] != r.ctrl[6:3])) begin
            n.st    = bbc_pkg::S_SYNC;
            n.bits  = 32'h0;
            n.errs  = 32'h0;
            n.cause = bbc_pkg::E_NONE;
            n.lcnt  = 4'h0;
            n.fill  = 6'h00;
            n.run   = 6'h00;
            n.ign   = 32'h0;
          end
          if (!wctrl[bbc_pkg::C_ON] && r.ctrl[bbc_pkg::C_ON]) begin
            if (r.st != bbc_pkg::S_IDLE && r.st != bbc_pkg::S_DONE) begin
              n.cause = bbc_pkg::E_USER;
            end
            n.st = (r.st == bbc_pkg::S_IDLE) ? bbc_pkg::S_IDLE : bbc_pkg::S_DONE;
          end
          if (wctrl[bbc_pkg::C_BON] && !r.ctrl[bbc_pkg::C_BON] && wctrl[bbc_pkg::C_BAUTO]) begin
            n.bact   = 1'b1;
            n.blks   = 32'h0;
            n.berrs  = 32'h0;
            n.bcause = bbc_pkg::E_NONE;
          end
          if (!wctrl[bbc_pkg::C_BON] && r.bact) begin
            n.bact   = 1'b0;
            n.bcause = bbc_pkg::E_USER;
          end
        end
        bbc_pkg::A_CMD: begin
          // single shots only while enabled in single mode
          if (wb_sel[0] && wb_dat_w[bbc_pkg::K_GO] && r.ctrl[bbc_pkg::C_ON] && !r.ctrl[bbc_pkg::C_AUTO]) begin
            n.st    = bbc_pkg::S_SYNC;
            n.bits  = 32'h0;
            n.errs  = 32'h0;
            n.cause = bbc_pkg::E_NONE;
            n.lcnt  = 4'h0;
            n.fill  = 6'h00;
            n.run   = 6'h00;
            n.ign   = 32'h0;
          end
          if (wb_sel[0] && wb_dat_w[bbc_pkg::K_BGO] && r.ctrl[bbc_pkg::C_BON] &&
              !r.ctrl[bbc_pkg::C_BAUTO]) begin
            n.bact   = 1'b1;
            n.blks   = 32'h0;
            n.berrs  = 32'h0;
            n.bcause = bbc_pkg::E_NONE;
          end
        end
        bbc_pkg::A_MAXB:  n.maxb  = bbc_merge(r.maxb, wb_dat_w, wb_sel);
        bbc_pkg::A_MAXE:  n.maxe  = bbc_merge(r.maxe, wb_dat_w, wb_sel);
        bbc_pkg::A_MAXK:  n.maxk  = bbc_merge(r.maxk, wb_dat_w, wb_sel);
        bbc_pkg::A_MAXKE: n.maxke = bbc_merge(r.maxke, wb_dat_w, wb_sel);
        default: ; // read-only or unmapped: ignored
      endcase
    end
    n.sync = (n.st == bbc_pkg::S_RUN) & n.clk_ok & n.data_ok;
    // read data is captured with the ack, zero when unmapped
    case (wb_adr[5:2])
      bbc_pkg::A_CTRL:  n.rdat = {21'h0, r.ctrl};
      bbc_pkg::A_STAT:  n.rdat = {23'h0, r.bact, active, r.bcause, r.cause, r.sync, r.data_ok, r.clk_ok};
      bbc_pkg::A_MAXB:  n.rdat = r.maxb;
      bbc_pkg::A_MAXE:  n.rdat = r.maxe;
      bbc_pkg::A_BITS:  n.rdat = r.bits;
      bbc_pkg::A_ERRS:  n.rdat = r.errs;
      bbc_pkg::A_MAXK:  n.rdat = r.maxk;
      bbc_pkg::A_MAXKE: n.rdat = r.maxke;
      bbc_pkg::A_BLKS:  n.rdat = r.blks;
      bbc_pkg::A_BERRS: n.rdat = r.berrs;
      default:          n.rdat = 32'h0;
    endcase
  end

  // register the copy; detectors start in the absent state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r       <= '0;
      r.ctrl  <= bbc_pkg::RST_CTRL;
      r.maxb  <= bbc_pkg::RST_MAXB;
      r.maxe  <= bbc_pkg::RST_MAXE;
      r.maxk  <= bbc_pkg::RST_MAXK;
      r.maxke <= bbc_pkg::RST_MAXKE;
      r.st    <= bbc_pkg::S_IDLE;
      r.ccnt  <= bbc_pkg::DET_CYC;
      r.dcnt  <= bbc_pkg::DET_CYC;
    end else begin
      r <= n;
    end
  end

  assign wb_ack   = r.ack;
  assign wb_dat_r = r.rdat;

  // checks on the measurement sequencing
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_halt_req;
    bit_stb && rs_rise && active && !wr;
  endsequence

  sequence s_done_quiet;
    (r.st == bbc_pkg::S_DONE && !wr)[*2];
  endsequence

  chk_restart_halt: assert property (s_halt_req |=> r.st == bbc_pkg::S_HALT)
    else $error("restart rise did not halt");
  chk_restart_flush: assert property (s_halt_req |=> r.fill == 6'h00 && r.ign == 32'h0)
    else $error("detector not flushed on restart");
  chk_restart_resync: assert property (r.st == bbc_pkg::S_HALT && rs_fall && !wr |=>
                                       r.st == bbc_pkg::S_SYNC && r.lcnt == 4'h0)
    else $error("restart fall did not resync");
  chk_restart_off: assert property (!r.ctrl[bbc_pkg::C_RST] && r.st == bbc_pkg::S_RUN && !wr |=>
                                    r.st != bbc_pkg::S_HALT)
    else $error("halt without restart enabled");
  chk_unqual_hold: assert property (bit_stb && !q && !wr |=> $stable(r.bits) && $stable(r.dly))
    else $error("unqualified bit changed state");
  chk_sync_needs: assert property (r.sync |-> r.clk_ok && r.data_ok && r.st == bbc_pkg::S_RUN)
    else $error("sync without clock and data");
  chk_done_cause: assert property ($rose(r.st == bbc_pkg::S_DONE) |-> r.cause != bbc_pkg::E_NONE)
    else $error("measurement ended without cause");
  chk_done_hold: assert property (s_done_quiet |-> $stable(r.bits) && $stable(r.errs))
    else $error("final result changed while done");
endmodule

// *** test/bbc_tester_model.sv ***
// tester model: bit clock, reference data, qualifier and restart lines
// assumes the bench asks for bits by raising want; clock idles at the pol_in level
`timescale 1ns/1ns
module bbc_tester_model (
  input  wire logic        qual_in,
  input  wire logic        rst_in,
  input  wire logic        pol_in,
  input  wire logic [31:0] want,
  input  wire logic [31:0] err_at,
  output logic      [31:0] sent,
  output logic             tst_clk,
  output logic             tst_data,
  output logic             tst_qual,
  output logic             tst_restart
);
  logic [8:0] hist; // last nine true bits, [0] newest
  logic       nb;   // next true bit
  logic       ck;   // clock level before polarity
  logic       dt;   // data level before polarity
  // polarity flips clock and data together, so the active edge stays mid-bit
  assign tst_clk  = ck ^ pol_in;
  assign tst_data = dt ^ pol_in;
  // one bit per 400 ns period, clock stands still between requests
  initial begin
    hist = 9'h1ff;
    sent = 32'h0;
    {ck, dt, tst_qual, tst_restart} = 4'h0;
    forever begin
      wait (sent < want);
      nb = hist[8] ^ hist[4];
      // lines move only while the clock is low, stable around the rise
      tst_qual = qual_in;
      tst_restart = rst_in;
      if (rst_in) begin
        // junk bit, next frame on a fresh seed so a stale reference fails
        dt = ~nb;
        hist = 9'h0a5;
      end else if (!qual_in) begin
        dt = ~nb; // filler, sequence paused
      end else begin
        dt = nb ^ (sent == err_at);
        hist = {hist[7:0], nb};
      end
      #200 ck = 1'b1;
      #200 ck = 1'b0;
      sent = sent + 32'h1;
    end
  end
endmodule

// *** test/testbench.sv ***
// self-checking bench for the bit and block error checker
// assumes the tester model on the pins and a classic wishbone master here
`timescale 1ns/1ns
module testbench;
  logic        clk, reset, wb_cyc, wb_stb, wb_we, wb_ack, q_r, r_r, p_r;
  logic        tst_clk, tst_data, tst_qual, tst_restart;
  logic [5:0]  wb_adr;
  logic [31:0] wb_dat_w, wb_dat_r, rd, want, err_at, sent;
  int          err_count, checked, cyc;
  logic [36:0] rows[10]; // write flag, word index, data or expected value

  bbc_checker DUT (.clk(clk), .reset(reset), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(4'hf), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .tst_clk(tst_clk), .tst_data(tst_data), .tst_qual(tst_qual), .tst_restart(tst_restart));
  bbc_tester_model tm (.qual_in(q_r), .rst_in(r_r), .pol_in(p_r), .want(want), .err_at(err_at), .sent(sent),
    .tst_clk(tst_clk), .tst_data(tst_data), .tst_qual(tst_qual), .tst_restart(tst_restart));

  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= {a, 2'b00};
    wb_dat_w <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    cmp({31'h0, wb_ack}, 32'h1);
  endtask
  task automatic chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    cmp(rd & m, e);
  endtask
  // ask the model for n bits and wait until the last one is counted
  task automatic bits(input logic [31:0] n, input logic q, input logic r);
    q_r = q;
    r_r = r;
    want = want + n;
    wait (sent == want);
    repeat (4) @(posedge clk);
  endtask
  task automatic summarize();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    {reset, q_r} = 2'h3;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w, r_r, p_r, want, cyc, err_count, checked} = '0;
    err_at = 32'hffffffff;
    rows = '{{1'b0, bbc_pkg::A_CTRL, 32'h0}, {1'b0, bbc_pkg::A_MAXB, bbc_pkg::RST_MAXB},
      {1'b0, bbc_pkg::A_MAXE, bbc_pkg::RST_MAXE}, {1'b0, bbc_pkg::A_MAXK, bbc_pkg::RST_MAXK},
      {1'b0, bbc_pkg::A_MAXKE, bbc_pkg::RST_MAXKE}, {1'b0, bbc_pkg::A_BITS, 32'h0},
      {1'b0, bbc_pkg::A_BLKS, 32'h0}, {1'b1, bbc_pkg::A_MAXKE, 32'h0000a5c3},
      {1'b0, bbc_pkg::A_MAXKE, 32'h0000a5c3}, {1'b0, 4'hf, 32'h0}};
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      wb(rows[i][36], rows[i][35:32], rows[i][31:0]);
      if (!rows[i][36]) cmp(rd, rows[i][31:0]);
    end
    // continuous run: nine bits load the reference, then counting
    wb(1'b1, bbc_pkg::A_CTRL, 32'h003);
    bits(32'h31, 1'b1, 1'b0);
    chk(bbc_pkg::A_BITS, 32'hffffffff, 32'h28);
    chk(bbc_pkg::A_ERRS, 32'hffffffff, 32'h0);
    chk(bbc_pkg::A_STAT, 32'h7, 32'h7);
    err_at = sent + 32'h5;
    bits(32'h14, 1'b1, 1'b0);
    chk(bbc_pkg::A_BITS, 32'hffffffff, 32'h3c);
    chk(bbc_pkg::A_ERRS, 32'hffffffff, 32'h1);
    // user stop holds the result, later pin traffic changes nothing
    wb(1'b1, bbc_pkg::A_CTRL, 32'h0);
    chk(bbc_pkg::A_STAT, 32'h18, 32'h08);
    bits(32'h5, 1'b1, 1'b0);
    chk(bbc_pkg::A_BITS, 32'hffffffff, 32'h3c);
    // outside restart: halt, fresh seed, resync, partial counts add
    wb(1'b1, bbc_pkg::A_CTRL, 32'h007);
    bits(32'h13, 1'b1, 1'b0);
    bits(32'h2, 1'b1, 1'b1);
    // 10 counted, then the fall bit only rearms sync, 9 load, 9 counted
    bits(32'h13, 1'b1, 1'b0);
    chk(bbc_pkg::A_BITS, 32'hffffffff, 32'h13);
    chk(bbc_pkg::A_ERRS, 32'hffffffff, 32'h0);
    // qualifier mode change restarts, blocks on in auto; wrong filler bits while unqualified
    wb(1'b1, bbc_pkg::A_CTRL, 32'h60b);
    bits(32'hf, 1'b1, 1'b0);
    bits(32'h6, 1'b0, 1'b0);
    bits(32'ha, 1'b1, 1'b0);
    chk(bbc_pkg::A_BITS, 32'hffffffff, 32'h10);
    chk(bbc_pkg::A_ERRS, 32'hffffffff, 32'h0);
    chk(bbc_pkg::A_BLKS, 32'hffffffff, 32'h1);
    // one bad bit, then a qualifier drop closes an errored block
    err_at = sent + 32'h1;
    bits(32'h3, 1'b1, 1'b0);
    bits(32'h1, 1'b0, 1'b0);
    chk(bbc_pkg::A_BLKS, 32'hffffffff, 32'h2);
    chk(bbc_pkg::A_BERRS, 32'hffffffff, 32'h1);
    // falling active edge and inverted data, both flipped at the pins; counting carries on
    wb(1'b1, bbc_pkg::A_CTRL, 32'h78b);
    p_r = 1'b1;
    bits(32'h8, 1'b1, 1'b0);
    chk(bbc_pkg::A_BITS, 32'hffffffff, 32'h1b);
    chk(bbc_pkg::A_ERRS, 32'hffffffff, 32'h1);
    // mid-run reset clears counts and state
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    chk(bbc_pkg::A_BLKS, 32'hffffffff, 32'h0);
    chk(bbc_pkg::A_STAT, 32'h1fc, 32'h0);
    summarize();
  end
endmodule
